// File: rtl/asf_pkg.sv
// constants, op codes and field layout of the processor flags block
// assumes one core clock; execution unit and bus share it
//
// Contract
// - flag-setting op to flags: data for arithmetic flags dropped
// - timeout and power-down bits ignore writes
// - clear-file on flags: upper zero, zero flag set
// - bits 7-5 read zero, writes ignored
// - timeout flag: set on power-up/clear/sleep, cleared on timeout
// - power-down flag: set on power-up/clear, cleared on sleep
// - zero flag follows result equal to zero
// - nibble carry from bit 3 on add/subtract
// - carry from bit 7 on add/subtract
// - subtract adds two's complement; carries mean no borrow
// - rotates load carry with bit shifted out
// - power-on reset 1/1/0/0/0; others keep arithmetic flags
package asf_pkg;
    localparam int ASF_DW = 8;
    localparam int ASF_NIB = 4;
    localparam int ASF_BIT_TO = 4;
    localparam int ASF_BIT_PD = 3;
    localparam int ASF_BIT_Z = 2;
    localparam int ASF_BIT_DC = 1;
    localparam int ASF_BIT_C = 0;
    localparam logic [31:0] ASF_FLAGS_OFS = 32'h0000_0000;
    localparam logic [31:0] ASF_RESULT_OFS = 32'h0000_0004;
    localparam logic [7:0] ASF_POR_FLAGS = 8'h18;
    localparam logic ASF_POR_CAUSE = 1'b1;
    localparam logic ASF_POR_ARITH = 1'b0;
    localparam logic [2:0] ASF_UNIMPL = 3'h0;
    localparam logic [1:0] ASF_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ASF_HSIZE_WORD = 3'h2;
    localparam logic ASF_HRESP_OKAY = 1'b0;
    localparam logic [31:0] ASF_RD_ZERO = 32'h0000_0000;

    typedef enum logic [4:0] {
        ASF_OP_NOP, ASF_OP_ADD, ASF_OP_SUB, ASF_OP_AND, ASF_OP_IOR,
        ASF_OP_XOR, ASF_OP_COM, ASF_OP_CLR, ASF_OP_INC, ASF_OP_DEC,
        ASF_OP_MOVE, ASF_OP_SWAP, ASF_OP_BITCLR, ASF_OP_BITSET,
        ASF_OP_RRF, ASF_OP_RLF, ASF_OP_WDTCLR, ASF_OP_SLEEP
    } asf_op_t;
endpackage

// File: rtl/asf_adder.sv
// 8-bit adder with carry out of the low nibble and of the top bit
// assumes operand b already inverted by the caller for subtraction
`timescale 1ns/1ns
module asf_adder
    import asf_pkg::*;
(
    // operands
    input wire logic [ASF_DW-1:0] a,
    input wire logic [ASF_DW-1:0] b,
    input wire logic cin,
    // results
    output logic [ASF_DW-1:0] sum,
    output logic nib_carry,
    output logic carry
);
    logic [ASF_NIB:0] lo;
    logic [ASF_NIB:0] hi;

    assign lo = {1'b0, a[ASF_NIB-1:0]} + {1'b0, b[ASF_NIB-1:0]} + {{ASF_NIB{1'b0}}, cin};
    assign hi = {1'b0, a[ASF_DW-1:ASF_NIB]} + {1'b0, b[ASF_DW-1:ASF_NIB]} + {{ASF_NIB{1'b0}}, lo[ASF_NIB]};
    assign sum = {hi[ASF_NIB-1:0], lo[ASF_NIB-1:0]};
    assign nib_carry = lo[ASF_NIB];
    assign carry = hi[ASF_NIB];
endmodule // asf_adder

// File: rtl/asf_flags.sv
// processor flags register with result datapath and AHB-Lite slave
// assumes execution unit inputs on SYS_CLK, bus single word transfers
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module asf_flags (
    // clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic POR_RST,
    input wire logic WDT_RST,
    // execution unit
    input wire logic EXEC_VALID,
    input wire asf_pkg::asf_op_t EXEC_OP,
    input wire logic [7:0] EXEC_OPA,
    input wire logic [7:0] EXEC_OPB,
    input wire logic [2:0] EXEC_BITSEL,
    input wire logic EXEC_DEST_FLAGS,
    input wire logic WDT_TIMEOUT,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // results
    output logic [7:0] RESULT,
    output logic RESULT_VALID,
    output logic [7:0] FLAGS
);
    import asf_pkg::*;

    typedef struct packed {
        logic to;
        logic pd;
        logic z;
        logic dc;
        logic c;
        logic [ASF_DW-1:0] result;
        logic res_vld;
        logic wr_pend;
        logic wr_flags;
        logic [31:0] rdata;
        logic ready;
    } asf_state_t;

    asf_state_t st_q;
    asf_state_t st_d;

    logic [ASF_DW-1:0] add_b;
    logic add_cin;
    logic [ASF_DW-1:0] add_sum;
    logic add_nc;
    logic add_c;

    function automatic logic affects_z(input asf_op_t op);
        unique case (op)
            ASF_OP_ADD, ASF_OP_SUB, ASF_OP_AND, ASF_OP_IOR, ASF_OP_XOR,
            ASF_OP_COM, ASF_OP_CLR, ASF_OP_INC, ASF_OP_DEC: affects_z = 1'b1;
            default: affects_z = 1'b0;
        endcase
    endfunction

    function automatic logic affects_carry(input asf_op_t op);
        unique case (op)
            ASF_OP_ADD, ASF_OP_SUB: affects_carry = 1'b1;
            default: affects_carry = 1'b0;
        endcase
    endfunction

    function automatic logic is_rotate(input asf_op_t op);
        is_rotate = (op == ASF_OP_RRF) || (op == ASF_OP_RLF);
    endfunction

    function automatic logic [7:0] flag_byte(input asf_state_t s);
        flag_byte = {ASF_UNIMPL, s.to, s.pd, s.z, s.dc, s.c};
    endfunction

    // subtract as add of two's complement
    assign add_b = (EXEC_OP == ASF_OP_SUB) ? ~EXEC_OPB : EXEC_OPB;
    assign add_cin = (EXEC_OP == ASF_OP_SUB);

    asf_adder asf_adder_inst (
        .a(EXEC_OPA),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .nib_carry(add_nc),
        .carry(add_c)
    );

    always_comb begin
        logic [ASF_DW-1:0] res;
        logic [ASF_DW-1:0] onehot;
        logic nz;
        logic ndc;
        logic nc;
        res = '0;
        onehot = '0;
        nz = 1'b0;
        ndc = 1'b0;
        nc = 1'b0;
        st_d = st_q;
        // reset owns the edge: exec and bus dropped
        if (CE && !SRST) begin
            st_d.ready = 1'b1;
            st_d.wr_pend = 1'b0;
            st_d.res_vld = 1'b0;
            // bus data phase: only arithmetic bits written
            if (st_q.wr_pend && st_q.wr_flags) begin
                st_d.z = HWDATA[ASF_BIT_Z];
                st_d.dc = HWDATA[ASF_BIT_DC];
                st_d.c = HWDATA[ASF_BIT_C];
            end
            if (EXEC_VALID) begin
                onehot[EXEC_BITSEL] = 1'b1;
                nc = st_d.c;
                unique case (EXEC_OP)
                    ASF_OP_ADD, ASF_OP_SUB: res = add_sum;
                    ASF_OP_AND: res = EXEC_OPA & EXEC_OPB;
                    ASF_OP_IOR: res = EXEC_OPA | EXEC_OPB;
                    ASF_OP_XOR: res = EXEC_OPA ^ EXEC_OPB;
                    ASF_OP_COM: res = ~EXEC_OPA;
                    ASF_OP_CLR: res = '0;
                    ASF_OP_INC: res = EXEC_OPA + 8'h01;
                    ASF_OP_DEC: res = EXEC_OPA - 8'h01;
                    ASF_OP_MOVE: res = EXEC_OPA;
                    ASF_OP_SWAP: res = {EXEC_OPA[ASF_NIB-1:0], EXEC_OPA[ASF_DW-1:ASF_NIB]};
                    ASF_OP_BITCLR: res = EXEC_OPA & ~onehot;
                    ASF_OP_BITSET: res = EXEC_OPA | onehot;
                    ASF_OP_RRF: begin
                        res = {st_d.c, EXEC_OPA[ASF_DW-1:1]};
                        nc = EXEC_OPA[0];
                    end
                    ASF_OP_RLF: begin
                        res = {EXEC_OPA[ASF_DW-2:0], st_d.c};
                        nc = EXEC_OPA[ASF_DW-1];
                    end
                    ASF_OP_NOP, ASF_OP_WDTCLR, ASF_OP_SLEEP: res = '0;
                endcase
                nz = (res == '0);
                ndc = add_nc;
                if (affects_carry(EXEC_OP)) begin
                    nc = add_c;
                end
                st_d.result = res;
                st_d.res_vld = 1'b1;
                // plain write only for non-flag ops
                if (EXEC_DEST_FLAGS && !affects_z(EXEC_OP) && !is_rotate(EXEC_OP)) begin
                    st_d.z = res[ASF_BIT_Z];
                    st_d.dc = res[ASF_BIT_DC];
                    st_d.c = res[ASF_BIT_C];
                end
                if (affects_z(EXEC_OP)) begin
                    st_d.z = nz;
                end
                if (affects_carry(EXEC_OP)) begin
                    st_d.dc = ndc;
                end
                if (affects_carry(EXEC_OP) || is_rotate(EXEC_OP)) begin
                    st_d.c = nc;
                end
                if (EXEC_OP == ASF_OP_WDTCLR) begin
                    st_d.to = 1'b1;
                    st_d.pd = 1'b1;
                end
                if (EXEC_OP == ASF_OP_SLEEP) begin
                    st_d.to = 1'b1;
                    st_d.pd = 1'b0;
                end
            end
            if (WDT_TIMEOUT) begin
                st_d.to = 1'b0;
            end
            // address phase: decode and prepare read data
            if (HSEL && HREADY && (HTRANS == ASF_HTRANS_NONSEQ)) begin
                st_d.wr_pend = HWRITE && (HSIZE == ASF_HSIZE_WORD);
                st_d.wr_flags = (HADDR == ASF_FLAGS_OFS);
                st_d.rdata = ASF_RD_ZERO;
                if (!HWRITE && (HADDR == ASF_FLAGS_OFS)) begin
                    st_d.rdata[ASF_DW-1:0] = flag_byte(st_d);
                end
                if (!HWRITE && (HADDR == ASF_RESULT_OFS)) begin
                    st_d.rdata[ASF_DW-1:0] = st_d.result;
                end
            end
        end
        if (SRST) begin
            st_d.wr_pend = 1'b0;
            st_d.wr_flags = 1'b0;
            st_d.rdata = ASF_RD_ZERO;
            st_d.ready = 1'b1;
            st_d.res_vld = 1'b0;
            if (POR_RST) begin
                st_d.to = ASF_POR_CAUSE;
                st_d.pd = ASF_POR_CAUSE;
                st_d.z = ASF_POR_ARITH;
                st_d.dc = ASF_POR_ARITH;
                st_d.c = ASF_POR_ARITH;
                st_d.result = '0;
            end else if (WDT_RST) begin
                st_d.to = 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        st_q <= st_d;
    end

    assign HRDATA = st_q.rdata;
    assign HREADYOUT = st_q.ready;
    assign HRESP = ASF_HRESP_OKAY;
    assign RESULT = st_q.result;
    assign RESULT_VALID = st_q.res_vld;
    assign FLAGS = flag_byte(st_q);

    logic go;
    assign go = CE && EXEC_VALID && !SRST;

    property p_unimpl;
        @(posedge SYS_CLK) disable iff (SRST)
        HRDATA[31:ASF_DW] == '0 && FLAGS[7:5] == ASF_UNIMPL;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");

    property p_cause_ro;
        @(posedge SYS_CLK) disable iff (SRST)
        (CE && st_q.wr_pend && !EXEC_VALID && !WDT_TIMEOUT) |=> $stable(FLAGS[4:3]);
    endproperty
    a_cause_ro: assert property (p_cause_ro) else $error("cause bits changed by write");

    property p_dest_add;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_DEST_FLAGS && EXEC_OP == ASF_OP_ADD) |=> (FLAGS[0] == $past(add_c)) && (FLAGS[1] == $past(add_nc));
    endproperty
    a_dest_add: assert property (p_dest_add) else $error("written data overrode add flags");

    property p_clr;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_DEST_FLAGS && EXEC_OP == ASF_OP_CLR && !st_q.wr_pend) |=>
            FLAGS[2] && $stable(FLAGS[1:0]) && RESULT == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear on flags wrong");

    property p_timeout;
        @(posedge SYS_CLK) disable iff (SRST)
        (CE && WDT_TIMEOUT) |=> !FLAGS[4];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");

    property p_sleep;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_SLEEP && !WDT_TIMEOUT) |=> FLAGS[4:3] == 2'h2;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

    property p_zero;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && affects_z(EXEC_OP)) |=> FLAGS[2] == (RESULT == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");

    property p_nibble;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_ADD) |=> FLAGS[1] == (({1'b0, $past(EXEC_OPA[3:0])} + {1'b0, $past(EXEC_OPB[3:0])}) > 5'h0f);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble carry wrong");

    property p_borrow;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_SUB) |=> FLAGS[0] == ($past(EXEC_OPA) >= $past(EXEC_OPB));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

    property p_rot;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_RRF) |=> FLAGS[0] == $past(EXEC_OPA[0]);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");

    property p_por;
        @(posedge SYS_CLK)
        (SRST && POR_RST) |=> FLAGS == ASF_POR_FLAGS;
    endproperty
    a_por: assert property (p_por) else $error("power-on flags wrong");

    property p_wdt_rst;
        @(posedge SYS_CLK)
        (SRST && !POR_RST && WDT_RST) |=> !FLAGS[ASF_BIT_TO] && $stable(FLAGS[ASF_BIT_PD:ASF_BIT_C]);
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset flags wrong");

    property p_rotl;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_RLF) |=> FLAGS[ASF_BIT_C] == $past(EXEC_OPA[ASF_DW-1]);
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate left carry wrong");

    property p_carry;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_ADD) |=>
            FLAGS[ASF_BIT_C] == (({1'b0, $past(EXEC_OPA)} + {1'b0, $past(EXEC_OPB)}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("add carry wrong");

    property p_nib_sub;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_SUB) |=>
            FLAGS[ASF_BIT_DC] == ($past(EXEC_OPA[ASF_NIB-1:0]) >= $past(EXEC_OPB[ASF_NIB-1:0]));
    endproperty
    a_nib_sub: assert property (p_nib_sub) else $error("nibble borrow polarity wrong");

    property p_wdtclr;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_OP == ASF_OP_WDTCLR && !WDT_TIMEOUT) |=> FLAGS[ASF_BIT_TO] && FLAGS[ASF_BIT_PD];
    endproperty
    a_wdtclr: assert property (p_wdtclr) else $error("watchdog clear flags wrong");

    property p_plain;
        @(posedge SYS_CLK) disable iff (SRST)
        (go && EXEC_DEST_FLAGS && EXEC_OP == ASF_OP_MOVE) |=>
            FLAGS[ASF_BIT_Z:ASF_BIT_C] == $past(EXEC_OPA[ASF_BIT_Z:ASF_BIT_C]);
    endproperty
    a_plain: assert property (p_plain) else $error("plain write to flags lost");

    property p_hold;
        @(posedge SYS_CLK) disable iff (SRST)
        (!CE) |=> $stable(FLAGS) && $stable(RESULT) && $stable(RESULT_VALID) && $stable(HRDATA);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while enable low"); // clock enable

    c_dest_add: cover property (@(posedge SYS_CLK) go && EXEC_DEST_FLAGS && EXEC_OP == ASF_OP_ADD);
    c_sleep: cover property (@(posedge SYS_CLK) go && EXEC_OP == ASF_OP_SLEEP);
    c_timeout: cover property (@(posedge SYS_CLK) CE && WDT_TIMEOUT && !SRST);
    c_bus_wr: cover property (@(posedge SYS_CLK) CE && st_q.wr_pend && st_q.wr_flags);
    c_rotate: cover property (@(posedge SYS_CLK) go && is_rotate(EXEC_OP));
endmodule // asf_flags

// File: test/asf_exec_model.sv
// execution unit model: one instruction per call of run
// assumes callers use the flags block's clock, one process at a time
`timescale 1ns/1ns
module asf_exec_model (
    // clock
    input wire logic clk,
    // instruction out
    output logic valid,
    output asf_pkg::asf_op_t op,
    output logic [7:0] opa,
    output logic [7:0] opb,
    output logic [2:0] bitsel,
    output logic dest
);
    import asf_pkg::*;
    initial begin
        valid = 1'b0;
        op = ASF_OP_NOP;
        opa = 8'h00;
        opb = 8'h00;
        bitsel = 3'h0;
        dest = 1'b0;
    end
    task automatic run(input asf_op_t o, input logic [7:0] a, input logic [7:0] b, input logic d);
        @(posedge clk);
        valid <= 1'b1;
        op <= o;
        opa <= a;
        opb <= b;
        dest <= d;
        bitsel <= 3'($urandom);
        @(posedge clk);
        valid <= 1'b0;
        // released operands must not look stable
        opa <= ~a;
        opb <= ~b;
        #1;
    endtask
endmodule // asf_exec_model

// File: test/alu_status_flags_test.sv
// self-checking bench of the processor flags block
// assumes the execution unit model and the design package
`timescale 1ns/1ns
module alu_status_flags_test;
    import asf_pkg::*;
    logic sys_clk, srst, ce, por_rst, wdt_rst, wdt_timeout;
    logic hsel, hwrite, hreadyout, hresp, result_valid;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, w;
    logic [7:0] result, flags, ef, a, b, r;
    logic ev, ed, s, d;
    logic [2:0] ebit;
    asf_op_t eop;
    asf_op_t lop;
    logic [7:0] eopa, eopb;
    logic [9:0] x;
    logic [16:0] cor [4];
    int errors, check_count;

    asf_exec_model asf_exec_model_inst (.clk(sys_clk), .valid(ev), .op(eop), .opa(eopa), .opb(eopb),
        .bitsel(ebit), .dest(ed));
    asf_flags asf_flags_inst (.SYS_CLK(sys_clk), .SRST(srst), .CE(ce), .POR_RST(por_rst),
        .WDT_RST(wdt_rst), .EXEC_VALID(ev), .EXEC_OP(eop), .EXEC_OPA(eopa), .EXEC_OPB(eopb),
        .EXEC_BITSEL(ebit), .EXEC_DEST_FLAGS(ed), .WDT_TIMEOUT(wdt_timeout), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(ASF_HSIZE_WORD), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .RESULT(result), .RESULT_VALID(result_valid), .FLAGS(flags));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] dt, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= ASF_HTRANS_NONSEQ;
        haddr <= ad;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dt;
        wait_rdy();
        q = hrdata;
        hwdata <= ~dt;
        chk("okay", 32'h0, {31'h0, hresp});
        #1;
    endtask

    task automatic ex(input asf_op_t o, input logic [7:0] oa, input logic [7:0] ob, input logic od);
        asf_exec_model_inst.run(o, oa, ob, od);
        chk("valid", 32'h1, {31'h0, result_valid});
        chk("flags", {24'h0, ef}, {24'h0, flags});
    endtask

    task automatic do_rst(input logic p, input logic wd);
        @(posedge sys_clk);
        srst <= 1'b1;
        por_rst <= p;
        wdt_rst <= wd;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        por_rst <= 1'b0;
        wdt_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // sum with carries: {nibble carry, carry, sum}
    function automatic logic [9:0] addx(input logic [7:0] p, input logic [7:0] q, input logic sub);
        logic [7:0] qq;
        logic [4:0] lo;
        logic [8:0] full;
        qq = sub ? ~q : q;
        lo = {1'b0, p[3:0]} + {1'b0, qq[3:0]} + {4'h0, sub};
        full = {1'b0, p} + {1'b0, qq} + {8'h0, sub};
        return {lo[4], full};
    endfunction

    // result of the logic, move and bit ops
    function automatic logic [7:0] lres(input asf_op_t o, input logic [7:0] p, input logic [7:0] q,
        input logic [2:0] k);
        case (o)
            ASF_OP_AND: return p & q;
            ASF_OP_IOR: return p | q;
            ASF_OP_XOR: return p ^ q;
            ASF_OP_COM: return ~p;
            ASF_OP_INC: return p + 8'h01;
            ASF_OP_DEC: return p - 8'h01;
            ASF_OP_MOVE: return p;
            ASF_OP_SWAP: return {p[3:0], p[7:4]};
            ASF_OP_BITCLR: return p & ~(8'h01 << k);
            ASF_OP_BITSET: return p | (8'h01 << k);
            default: return 8'h00;
        endcase
    endfunction

    initial begin
        {srst, por_rst, ce} = 3'b111;
        {wdt_rst, wdt_timeout, hsel, hwrite} = 4'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        errors = 0;
        check_count = 0;
        cor = '{17'h0_0f01, 17'h0_ff01, 17'h1_3c3c, 17'h1_1001};
        void'($urandom(60401));
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        ef = ASF_POR_FLAGS;
        chk("por flags", 32'h18, {24'h0, flags});
        bus(1'b0, ASF_FLAGS_OFS, 32'h0, rd);
        chk("por read", 32'h18, rd);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            {s, a, b} = (i < 4) ? cor[i] : 17'($urandom);
            d = 1'($urandom);
            x = addx(a, b, s);
            ef[2:0] = {x[7:0] == 8'h00, x[9], x[8]};
            ex(s ? ASF_OP_SUB : ASF_OP_ADD, a, b, d);
            chk("sum", {24'h0, x[7:0]}, {24'h0, result});
        end
        $display("test add sub done");
        for (int i = 0; i < 8; i++) begin
            a = 8'($urandom);
            r = i[0] ? {a[6:0], ef[0]} : {ef[0], a[7:1]};
            ef[0] = i[0] ? a[7] : a[0];
            ex(i[0] ? ASF_OP_RLF : ASF_OP_RRF, a, 8'h00, 1'b0);
            chk("rotate", {24'h0, r}, {24'h0, result});
        end
        $display("test rotate done");
        for (int i = 0; i < 22; i++) begin
            lop = asf_op_t'(5'(int'(ASF_OP_AND) + i % 11));
            a = (i < 11) ? 8'($urandom) : 8'hff;
            b = (i < 11) ? 8'($urandom) : 8'hff;
            d = (lop == ASF_OP_MOVE || lop == ASF_OP_SWAP) ? 1'($urandom) : 1'b0;
            r = lres(lop, a, b, 3'h0);
            if (lop <= ASF_OP_DEC) begin
                ef[2] = (r == 8'h00);
            end
            if (d) begin
                ef[2:0] = r[2:0];
            end
            ex(lop, a, b, d);
            chk("logic", {24'h0, lres(lop, a, b, ebit)}, {24'h0, result});
        end
        $display("test logic done");
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 32'hffff_ffff : (i == 4) ? 32'h0000_00e3 : $urandom;
            ef[2:0] = w[2:0];
            bus(1'b1, ASF_FLAGS_OFS, w, rd);
            bus(1'b0, ASF_FLAGS_OFS, 32'h0, rd);
            chk("flags read", {24'h0, ef}, rd);
        end
        ef[2:0] = {1'b1, ef[1:0]};
        ex(ASF_OP_CLR, 8'hff, 8'h00, 1'b1);
        a = 8'($urandom);
        r = {a[3:0], a[7:4]};
        ef[2:0] = r[2:0];
        ex(ASF_OP_SWAP, a, 8'h00, 1'b1);
        chk("swap", {24'h0, r}, {24'h0, result});
        x = addx(8'h12, 8'h34, 1'b0);
        ef[2:0] = {1'b0, x[9], x[8]};
        ex(ASF_OP_ADD, 8'h12, 8'h34, 1'b0);
        @(posedge sys_clk);
        ce <= 1'b0;
        asf_exec_model_inst.run(ASF_OP_CLR, 8'h55, 8'h00, 1'b1);
        chk("frozen flags", {24'h0, ef}, {24'h0, flags});
        chk("frozen valid", 32'h0, {31'h0, result_valid});
        chk("frozen result", 32'h46, {24'h0, result});
        @(posedge sys_clk);
        ce <= 1'b1;
        bus(1'b1, ASF_RESULT_OFS, 32'h0000_00ff, rd);
        bus(1'b0, ASF_RESULT_OFS, 32'h0, rd);
        chk("result read", 32'h46, rd);
        bus(1'b0, 32'h0000_0008, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        $display("test bus done");
        @(posedge sys_clk);
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        @(posedge sys_clk);
        #1;
        ef[4] = 1'b0;
        chk("timeout", {24'h0, ef}, {24'h0, flags});
        ef[4:3] = 2'b10;
        ex(ASF_OP_SLEEP, 8'h00, 8'h00, 1'b0);
        ef[4:3] = 2'b11;
        ex(ASF_OP_WDTCLR, 8'h00, 8'h00, 1'b0);
        ef[2:0] = 3'h5;
        bus(1'b1, ASF_FLAGS_OFS, 32'h0000_0005, rd);
        do_rst(1'b0, 1'b1);
        ef[4] = 1'b0;
        chk("wdt reset", {24'h0, ef}, {24'h0, flags});
        do_rst(1'b0, 1'b0);
        chk("plain reset", {24'h0, ef}, {24'h0, flags});
        do_rst(1'b1, 1'b0);
        chk("por again", 32'h18, {24'h0, flags});
        $display("test watchdog done");
        test_done();
    end
endmodule // alu_status_flags_test
